/* scdc_cfg.svh */
// constants for the system clock divider control block
`ifndef SCDC_CFG_SVH
`define SCDC_CFG_SVH
`define SCDC_ADDR_W 4
`define SCDC_ADDR_CTRL 4'h0
`define SCDC_ADDR_STAT 4'h1
`define SCDC_CTRL_RESET 8'h00
`define SCDC_HOLD_BIT 7
`define SCDC_RSVD_HI 6
`define SCDC_RSVD_LO 3
`define SCDC_SEL_HI 2
`define SCDC_SEL_LO 0
`define SCDC_SEL_DIV1 3'h0
`define SCDC_SEL_DIV2 3'h1
`define SCDC_SEL_DIV4 3'h2
`define SCDC_CLK_HZ 25000000
`define SCDC_SETTLE_US 500
`define SCDC_SETTLE_CYC ((`SCDC_SETTLE_US * (`SCDC_CLK_HZ / 1000000)))
`define SCDC_DUTY_MIN_HZ 5000000
`endif

/* scdc_pkg.sv */
// types for the system clock divider control block
package scdc_pkg;
   typedef enum logic [1:0] {
      SCDC_MODE_NORMAL = 2'b00,
      SCDC_MODE_SLEEP = 2'b01,
      SCDC_MODE_SWSTBY = 2'b10,
      SCDC_MODE_HWSTBY = 2'b11
   } scdc_mode_t;
   typedef enum logic [1:0] {
      SCDC_ST_SETTLE = 2'b00,
      SCDC_ST_RUN = 2'b01
   } scdc_state_t;
endpackage

/* scdc_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module scdc_sync (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // level
   input wire logic din_i,
   output logic dout_o
);
   typedef struct packed {
      logic s1;
      logic s2;
   } scdc_sync_t;
   scdc_sync_t st_q, st_d;
   always_comb begin
      st_d = st_q;
      st_d.s1 = din_i;
      st_d.s2 = st_q.s1;
   end
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign dout_o = st_q.s2;
endmodule

/* scdc_divider.sv */
// divide-by-1/2/4 enable generator
`timescale 1ns/1ps
`include "scdc_cfg.svh"
module scdc_divider (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic [2:0] sel_i,
   // enable out
   output logic tick_o,
   output logic phase_o
);
   typedef struct packed {
      logic [1:0] cnt;
      logic tick;
      logic phase;
   } scdc_div_t;
   scdc_div_t st_q, st_d;
   logic [1:0] last;
   always_comb begin
      st_d = st_q;
      if (sel_i == `SCDC_SEL_DIV4) begin
         last = 2'h3;
      end else if (sel_i == `SCDC_SEL_DIV2) begin
         last = 2'h1;
      end else begin
         last = 2'h0;
      end
      st_d.tick = 1'b0;
      if (!run_i) begin
         st_d.cnt = 2'h0;
         st_d.phase = 1'b0;
      end else if (st_q.cnt >= last) begin
         st_d.cnt = 2'h0;
         st_d.tick = 1'b1;
         st_d.phase = ~st_q.phase;
      end else begin
         st_d.cnt = st_q.cnt + 2'h1;
      end
   end
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign tick_o = st_q.tick;
   assign phase_o = st_q.phase;
endmodule

/* scdc_top.sv */
// system clock divider control: register, divider and clock output pin
`timescale 1ns/1ps
`include "scdc_cfg.svh"
module scdc_top
   import scdc_pkg::*;
#(
   parameter int SETTLE_CYC = `SCDC_SETTLE_CYC,
   parameter int OSC_HZ = 20000000
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // register port
   input wire logic [`SCDC_ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // power-down mode from the mode controller, same clock
   input wire logic [1:0] pwr_mode_i,
   // active-low chip reset pin
   input wire logic chip_rst_n_i,
   // system clock output pin
   output logic sysclk_pin_o,
   output logic sysclk_pin_oe_o,
   // internal system clock enable and status
   output logic sysclk_tick_o,
   output logic clk_ready_o,
   output logic duty_adj_o
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] rdata;
      scdc_state_t state;
      logic [31:0] settle;
      logic pin;
      logic oe;
   } scdc_top_t;
   scdc_top_t st_q, st_d;
   logic rst_pin_n;
   logic tick;
   logic phase;
   logic run;
   scdc_mode_t mode;

   function automatic logic [7:0] scdc_read(input logic [`SCDC_ADDR_W-1:0] a,
                                            input logic [7:0] c, input logic rdy);
      if (a == `SCDC_ADDR_CTRL) begin
         scdc_read = c;
      end else if (a == `SCDC_ADDR_STAT) begin
         scdc_read = {7'h00, rdy};
      end else begin
         scdc_read = 8'h00;
      end
   endfunction

   function automatic logic scdc_is_run(input scdc_state_t s);
      scdc_is_run = (s == SCDC_ST_RUN);
   endfunction

   // both standby modes stop the system clock
   function automatic logic scdc_tick_open(input scdc_mode_t m);
      scdc_tick_open = (m == SCDC_MODE_NORMAL) || (m == SCDC_MODE_SLEEP);
   endfunction

   // parked high, not low, so a stopped clock leaves no stray falling edge behind
   function automatic logic scdc_pin_forced(input scdc_mode_t m, input logic hold,
                                            input logic running);
      if (!running) begin
         scdc_pin_forced = 1'b1;
      end else if (m == SCDC_MODE_SWSTBY) begin
         scdc_pin_forced = 1'b1;
      end else begin
         scdc_pin_forced = hold;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin sync and divider
   scdc_sync u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .din_i(chip_rst_n_i),
      .dout_o(rst_pin_n)
   );
   scdc_divider u_div (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .run_i(run),
      .sel_i(st_q.ctrl[`SCDC_SEL_HI:`SCDC_SEL_LO]),
      .tick_o(tick),
      .phase_o(phase)
   );
   assign mode = scdc_mode_t'(pwr_mode_i);
   assign run = scdc_is_run(st_q.state);

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_d = st_q;
      // whole byte kept, reserved bits included; prohibited codes are software's duty
      if (reg_wr_i && reg_addr_i == `SCDC_ADDR_CTRL) begin
         st_d.ctrl = reg_wdata_i;
      end
      if (reg_rd_i) begin
         st_d.rdata = scdc_read(reg_addr_i, st_q.ctrl, run);
      end else begin
         st_d.rdata = 8'h00;
      end
      // pin reset restarts the settle wait; the outside holds it low long enough
      case (st_q.state)
         SCDC_ST_SETTLE: begin
            if (!rst_pin_n) begin
               st_d.settle = 32'h0;
               st_d.ctrl = `SCDC_CTRL_RESET;
            end else if (st_q.settle >= 32'(SETTLE_CYC - 1)) begin
               st_d.state = SCDC_ST_RUN;
            end else begin
               st_d.settle = st_q.settle + 32'h1;
            end
         end
         SCDC_ST_RUN: begin
            if (!rst_pin_n) begin
               st_d.state = SCDC_ST_SETTLE;
               st_d.settle = 32'h0;
               st_d.ctrl = `SCDC_CTRL_RESET;
            end
         end
         default: st_d.state = SCDC_ST_SETTLE;
      endcase
      // pin: high while unsettled, held or in software standby; float in hw standby
      st_d.oe = (mode != SCDC_MODE_HWSTBY);
      if (scdc_pin_forced(mode, st_q.ctrl[`SCDC_HOLD_BIT], run)) begin
         st_d.pin = 1'b1;
      end else begin
         st_d.pin = phase;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '0;
         st_q.ctrl <= `SCDC_CTRL_RESET;
         st_q.pin <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign reg_rdata_o = st_q.rdata;
   assign sysclk_pin_o = st_q.pin;
   assign sysclk_pin_oe_o = st_q.oe;
   // system clock stops in both standby modes
   assign sysclk_tick_o = tick && scdc_tick_open(mode);
   assign clk_ready_o = run;
   assign duty_adj_o = (OSC_HZ > `SCDC_DUTY_MIN_HZ);

   ////////////////////////////////////////////////////////////////////////
   // checks
   chk_reset_value: assert property (@(posedge clk_sys_i) $fell(rst_i) |-> st_q.ctrl == 8'h00)
      else $error("control not zero after reset");
   chk_write_store: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == `SCDC_ADDR_CTRL && rst_pin_n |=> st_q.ctrl == $past(reg_wdata_i))
      else $error("control write lost");
   chk_read_back: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == `SCDC_ADDR_CTRL |=> reg_rdata_o == $past(st_q.ctrl))
      else $error("control readback wrong");
   chk_rsvd_kept: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == `SCDC_ADDR_CTRL && rst_pin_n
      |=> st_q.ctrl[6:3] == $past(reg_wdata_i[6:3]))
      else $error("reserved bits not kept");
   chk_hold_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      st_q.ctrl[7] || mode == SCDC_MODE_SWSTBY |=> sysclk_pin_o)
      else $error("pin not held high");
   chk_hw_float: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      mode == SCDC_MODE_HWSTBY |=> !sysclk_pin_oe_o)
      else $error("pin driven in hardware standby");
   chk_settle_wait: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !clk_ready_o && !$past(clk_ready_o) |-> sysclk_pin_o && !tick)
      else $error("clock out before settle");
   chk_pin_reset: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !rst_pin_n |=> !clk_ready_o)
      else $error("ready during pin reset");
   chk_div_two: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      tick && st_q.ctrl[2:0] == 3'h1 && $stable(st_q.ctrl) && clk_ready_o
      |=> !tick ##1 (tick || !clk_ready_o || st_q.ctrl != $past(st_q.ctrl, 2)))
      else $error("half rate wrong");
   cov_div1: cover property (@(posedge clk_sys_i) clk_ready_o && st_q.ctrl[2:0] == 3'h0 && tick);
   cov_div4: cover property (@(posedge clk_sys_i) clk_ready_o && st_q.ctrl[2:0] == 3'h2 && tick);
   cov_hold: cover property (@(posedge clk_sys_i) clk_ready_o && st_q.ctrl[7]);
   cov_hwstby: cover property (@(posedge clk_sys_i) mode == SCDC_MODE_HWSTBY);
   cov_div2: cover property (@(posedge clk_sys_i) clk_ready_o && st_q.ctrl[2:0] == 3'h1 && tick);

   ////////////////////////////////////////////////////////////////////////
   // register side
   chk_write_sel: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == `SCDC_ADDR_CTRL && rst_pin_n
      |=> st_q.ctrl[2:0] == $past(reg_wdata_i[2:0]))
      else $error("select write lost");

   chk_write_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == `SCDC_ADDR_CTRL && rst_pin_n
      |=> st_q.ctrl[7] == $past(reg_wdata_i[7]))
      else $error("hold bit write lost");

   chk_wr_other: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i != `SCDC_ADDR_CTRL && rst_pin_n
      |=> st_q.ctrl == $past(st_q.ctrl))
      else $error("control changed by other write");

   chk_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !reg_rd_i
      |=> reg_rdata_o == 8'h00)
      else $error("read data without read");

   chk_stat_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == `SCDC_ADDR_STAT
      |=> reg_rdata_o == {7'h00, $past(clk_ready_o)})
      else $error("status readback wrong");

   chk_unmapped_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i != `SCDC_ADDR_CTRL && reg_addr_i != `SCDC_ADDR_STAT
      |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");

   ////////////////////////////////////////////////////////////////////////
   // clock pin
   chk_oe_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      mode != SCDC_MODE_HWSTBY
      |=> sysclk_pin_oe_o)
      else $error("pin not driven");

   chk_swstby_pin: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      mode == SCDC_MODE_SWSTBY
      |=> sysclk_pin_o && sysclk_pin_oe_o)
      else $error("pin not high in software standby");

   chk_pin_follow: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      clk_ready_o && !st_q.ctrl[`SCDC_HOLD_BIT] && scdc_tick_open(mode)
      |=> sysclk_pin_o == $past(phase))
      else $error("pin does not follow clock");

   chk_tick_stop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      mode == SCDC_MODE_SWSTBY || mode == SCDC_MODE_HWSTBY
      |-> !sysclk_tick_o)
      else $error("clock runs in standby");

   chk_tick_run: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      mode == SCDC_MODE_NORMAL && tick
      |-> sysclk_tick_o)
      else $error("clock lost in normal mode");

   chk_pin_reset_hi: assert property (@(posedge clk_sys_i)
      $fell(rst_i)
      |-> sysclk_pin_o)
      else $error("pin low after reset");

   ////////////////////////////////////////////////////////////////////////
   // settle and divider
   chk_div_four: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (tick && st_q.ctrl[2:0] == 3'h2 && clk_ready_o)
      ##1 (st_q.ctrl[2:0] == 3'h2 && clk_ready_o)[*3]
      |-> (!tick && !$past(tick) && !$past(tick, 2)) ##1 tick)
      else $error("quarter rate wrong");

   chk_div_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !clk_ready_o
      |=> !tick)
      else $error("divider runs while unsettled");

   chk_ready_keep: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      clk_ready_o && rst_pin_n
      |=> clk_ready_o)
      else $error("ready dropped without pin reset");

   chk_pin_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !rst_pin_n
      |=> st_q.ctrl == `SCDC_CTRL_RESET)
      else $error("control not cleared by pin reset");

   chk_settle_len: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(clk_ready_o)
      |-> $past(st_q.settle) == 32'(SETTLE_CYC - 1))
      else $error("settle wait too short");

   chk_ready_reset: assert property (@(posedge clk_sys_i)
      $fell(rst_i)
      |-> !clk_ready_o)
      else $error("ready right after reset");
endmodule

/* scdc_ext_src.sv */
// reset pin source that holds the chip reset low for HOLD_CYC cycles after reset and after each restart
`timescale 1ns/1ps
module scdc_ext_src #(
   parameter int HOLD_CYC = 4
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // restart request and standby level from the bench
   input wire logic again_i,
   input wire logic standby_i,
   // active-low chip reset pin
   output logic chip_rst_n_o,
   // level of the external clock source
   output logic osc_clk_o
);
   int cnt_q;
   logic osc_q;
   // low until the hold count has run out, again after each restart
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 0;
      end else if (again_i) begin
         cnt_q <= 0;
      end else if (cnt_q < HOLD_CYC) begin
         cnt_q <= cnt_q + 1;
      end
   end
   // an inverted source must rest high in standby
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         osc_q <= 1'b1;
      end else if (standby_i) begin
         osc_q <= 1'b1;
      end else begin
         osc_q <= ~osc_q;
      end
   end
   assign osc_clk_o = osc_q;
   assign chip_rst_n_o = (cnt_q >= HOLD_CYC) && !again_i;
endmodule

/* testbench.sv */
// self-checking testbench for the system clock divider control block
`timescale 1ns/1ps
`include "scdc_cfg.svh"
module testbench;
   import scdc_pkg::*;
   logic clk_sys_i = 0;
   logic rst_i = 1;
   logic [3:0] addr = 0;
   logic [7:0] wdata = 0;
   logic wr = 0;
   logic rd = 0;
   logic [1:0] mode = 0;
   logic again = 0;
   logic [7:0] rdata;
   logic [7:0] d;
   logic crn, pin, oe, tick, ready, duty, last, osc;
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   int nt, np, hi, en;
   scdc_ext_src u_scdc_ext_src (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .again_i(again),
      .standby_i(mode[1]), .chip_rst_n_o(crn), .osc_clk_o(osc));
   scdc_top #(.SETTLE_CYC(8)) u_scdc_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .pwr_mode_i(mode), .chip_rst_n_i(crn), .sysclk_pin_o(pin),
      .sysclk_pin_oe_o(oe), .sysclk_tick_o(tick), .clk_ready_o(ready), .duty_adj_o(duty));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ceiling well above the roughly 230 cycles the tests need
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         end_sim();
      end
   end
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk_sys_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      @(posedge clk_sys_i);
      d = rdata;
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 40 && ready !== 1'b1; i++) @(posedge clk_sys_i);
   endtask
   // let a setting land, then count ticks and pin toggles over n cycles
   task automatic meas(input int n);
      nt = 0;
      np = 0;
      hi = 1;
      en = 1;
      repeat (4) @(posedge clk_sys_i);
      last = pin;
      repeat (n) begin
         @(posedge clk_sys_i);
         nt += (tick === 1'b1);
         np += (pin !== last);
         last = pin;
         hi &= (pin === 1'b1);
         en &= (oe === 1'b1);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      chk(pin, 1);
      chk(ready, 0);
      wait_ready();
      chk(ready, 1);
      chk(duty, 1);
      rd_reg(`SCDC_ADDR_CTRL);
      chk(d, `SCDC_CTRL_RESET);
      wr_reg(`SCDC_ADDR_CTRL, 8'h78);
      rd_reg(`SCDC_ADDR_CTRL);
      chk(d, 8'h78);
      rd_reg(4'hF);
      chk(d, 8'h00);
      wr_reg(`SCDC_ADDR_STAT, 8'hFE);
      rd_reg(`SCDC_ADDR_STAT);
      chk(d, 8'h01);
      rd_reg(`SCDC_ADDR_CTRL);
      chk(d, 8'h78);
      $display("register test done");
      // only the permitted select codes are written
      for (int i = 0; i < 3; i++) begin
         wr_reg(`SCDC_ADDR_CTRL, 8'(i));
         meas(16);
         chk(8'(nt), 8'(16 >> i));
         chk(8'(np), 8'(16 >> i));
      end
      wr_reg(`SCDC_ADDR_CTRL, 8'h82);
      meas(16);
      chk(8'(nt), 8'h04);
      chk(8'(hi), 8'h01);
      chk(8'(en), 8'h01);
      $display("divider test done");
      wr_reg(`SCDC_ADDR_CTRL, 8'h01);
      for (int m = 0; m < 4; m++) begin
         mode <= 2'(m);
         meas(16);
         if (m < 3) chk(8'(np), (m < 2) ? 8'h08 : 8'h00);
         chk(8'(en), (m != 3) ? 8'h01 : 8'h00);
         if (m >= 2) chk(8'(osc), 8'h01);
      end
      mode <= 2'b00;
      $display("mode test done");
      @(posedge clk_sys_i);
      again <= 1'b1;
      @(posedge clk_sys_i);
      again <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      chk(ready, 0);
      rd_reg(`SCDC_ADDR_CTRL);
      chk(d, 8'h00);
      wait_ready();
      chk(ready, 1);
      $display("chip reset test done");
      end_sim();
   end
endmodule
